// file: utd_pkg.sv
// Constants, types and helpers shared by the tag command decoder
package utd_pkg;

   // Prefix-free opcode values
   localparam logic [1:0]  OPC_QUERYREP = 2'h0;
   localparam logic [1:0]  OPC_ACK      = 2'h1;
   localparam logic [3:0]  OPC_QUERY    = 4'h8;
   localparam logic [3:0]  OPC_QUERYADJ = 4'h9;
   localparam logic [3:0]  OPC_SELECT   = 4'hA;
   localparam logic [7:0]  OPC_NAK      = 8'hC0;
   localparam logic [7:0]  OPC_ACCESS   = 8'hC6;
   localparam logic [7:0]  OPC_MWRITE   = 8'hC7;
   localparam logic [7:0]  OPC_MERASE   = 8'hC8;

   // Opcode lengths and field widths in bits
   localparam logic [11:0] LEN_OPC_S    = 12'h002;
   localparam logic [11:0] LEN_OPC_M    = 12'h004;
   localparam logic [11:0] LEN_OPC_L    = 12'h008;
   localparam logic [11:0] LEN_OPC_FLD  = 12'h010;
   localparam logic [11:0] LEN_BANK     = 12'h002;
   localparam logic [11:0] LEN_EBV_BLK  = 12'h008;
   localparam logic [11:0] LEN_CNT      = 12'h008;
   localparam logic [11:0] LEN_HANDLE   = 12'h010;
   localparam logic [11:0] LEN_CRC      = 12'h010;
   localparam int          EBV_CONT_BIT = 7;

   // Bank selects and count limits
   localparam logic [1:0]  BANK_RSVD    = 2'h0;
   localparam logic [1:0]  BANK_EPC     = 2'h1;
   localparam logic [7:0]  MW_CNT_MIN   = 8'h01;
   localparam logic [7:0]  MW_CNT_MAX   = 8'h02;
   localparam logic [7:0]  ME_CNT_MIN   = 8'h01;
   localparam logic [7:0]  ME_CNT_MAX   = 8'h08;
   localparam logic [15:0] EPC_PC_ADDR  = 16'h0001;
   localparam logic [15:0] EPC_LAST_ADR = 16'h0009;
   localparam logic [15:0] ERASE_VALUE  = 16'h0000;

   // Tag error codes
   localparam logic [7:0]  ERR_OTHER    = 8'h00;
   localparam logic [7:0]  ERR_OVERRUN  = 8'h03;

   // CRC-16 (CCITT, preset ones, good residue)
   localparam logic [15:0] CRC_PRESET   = 16'hFFFF;
   localparam logic [15:0] CRC_POLY     = 16'h1021;
   localparam logic [15:0] CRC_RESIDUE  = 16'h1D0F;
   localparam logic [15:0] CRC_RST_VAL  = 16'h0000;

   // Register map (byte addresses) and fields
   localparam logic [4:0]  REG_CTRL     = 5'h00;
   localparam logic [4:0]  REG_STATUS   = 5'h04;
   localparam logic [4:0]  REG_CRC      = 5'h08;
   localparam logic [4:0]  REG_LAST     = 5'h0C;
   localparam int          CTRL_EN_BIT  = 0;
   localparam logic        CTRL_EN_RST  = 1'b1;
   localparam int          ST_VALID_BIT = 0;
   localparam int          ST_BUSY_BIT  = 1;
   localparam int          ST_ERR_LSB   = 8;
   localparam int          ST_CMD_LSB   = 16;
   localparam int          LAST_CNT_LSB = 16;

   typedef enum logic [3:0] {
      CMD_NONE, CMD_QUERYREP, CMD_ACK, CMD_QUERY, CMD_QUERYADJ, CMD_SELECT,
      CMD_MANDATORY, CMD_MWRITE, CMD_MERASE, CMD_UNKNOWN
   } utd_cmd_e;

   typedef enum {
      ST_IDLE, ST_OPC, ST_BANK, ST_PTR, ST_CNT, ST_DATA, ST_HANDLE, ST_CRC,
      ST_END, ST_SKIP, ST_EXEC
   } utd_state_e;

   function automatic logic [15:0] utd_crc_step(input logic [15:0] c, input logic b);
      logic fb;
      fb = c[15] ^ b;
      return {c[14:0], 1'b0} ^ (fb ? CRC_POLY : CRC_RST_VAL);
   endfunction

   function automatic logic in_range(input logic [7:0] v, input logic [7:0] lo,
                                     input logic [7:0] hi);
      return (v >= lo) && (v <= hi);
   endfunction

   // Command of the opcode bits seen so far, valid only at a decision point
   function automatic utd_cmd_e utd_decode(input logic [7:0] code, input logic [11:0] n);
      utd_cmd_e id;
      id = CMD_UNKNOWN;
      if (n == LEN_OPC_S) begin
         id = (code[1:0] == OPC_ACK) ? CMD_ACK : CMD_QUERYREP;
      end else if (n == LEN_OPC_M) begin
         case (code[3:0])
            OPC_QUERY:    id = CMD_QUERY;
            OPC_QUERYADJ: id = CMD_QUERYADJ;
            OPC_SELECT:   id = CMD_SELECT;
            default:      id = CMD_UNKNOWN;
         endcase
      end else if (code >= OPC_NAK && code <= OPC_ACCESS) begin
         id = CMD_MANDATORY;
      end else if (code == OPC_MWRITE) begin
         id = CMD_MWRITE;
      end else if (code == OPC_MERASE) begin
         id = CMD_MERASE;
      end
      return id;
   endfunction

endpackage

// file: utd_cmd_decoder.sv
// Tag command decoder: opcode decode, multi-word write/erase checks, stored CRC upkeep
//
// Implementation choices: the Avalon-MM slave port and the address map.
`timescale 1ns/1ps
module utd_cmd_decoder
   import utd_pkg::*;
(
   input  wire logic        clk_sys,
   input  wire logic        arst_n,
   input  wire logic [4:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   input  wire logic [3:0]  avs_byteenable,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   input  wire logic        rx_frame_start,
   input  wire logic        rx_frame_end,
   input  wire logic        rx_bit_valid,
   input  wire logic        rx_bit,
   input  wire logic [15:0] session_handle,
   input  wire logic        epc_write_evt,
   input  wire logic        ack_reply_end,
   input  wire logic        ack_reply_full,
   input  wire logic [15:0] ack_reply_crc,
   output logic             cmd_pulse,
   output logic      [3:0]  cmd_id,
   output logic             mem_wr,
   output logic      [15:0] mem_wr_addr,
   output logic      [15:0] mem_wr_data,
   output logic             reply_ok,
   output logic             reply_err,
   output logic      [7:0]  reply_err_code,
   output logic      [15:0] stored_crc_word,
   output logic             stored_crc_valid
);

   utd_state_e  state_r;
   utd_cmd_e    cmd_r;
   logic [11:0] bcnt_r;
   logic [15:0] opc_r;
   logic [1:0]  bank_r;
   logic [7:0]  ebv_blk_r;
   logic [15:0] word_pointer_r;
   logic [7:0]  word_count_a_r;
   logic [15:0] data_r [2];
   logic [15:0] handle_r;
   logic [15:0] crc_r;
   logic        overlong_r;
   logic [7:0]  exec_idx_r;
   logic        en_r;
   logic        wait_r;
   logic [31:0] rdata_r;
   logic [11:0] n_c;
   logic        is_write_c;
   logic        accept_c;
   logic        bank_ok_c;
   logic        count_ok_c;
   logic        epc_hit_c;
   logic [7:0]  code_c;
   logic        decide_c;
   logic        take_c;
   utd_cmd_e    dec_c;

   assign n_c        = bcnt_r + 12'h001;
   assign is_write_c = (cmd_r == CMD_MWRITE);
   assign bank_ok_c  = (bank_r == BANK_EPC);
   assign count_ok_c = is_write_c ? in_range(word_count_a_r, MW_CNT_MIN, MW_CNT_MAX)
                                  : in_range(word_count_a_r, ME_CNT_MIN, ME_CNT_MAX);
   assign accept_c   = (state_r == ST_END) && rx_frame_end && !overlong_r && en_r &&
                       (crc_r == CRC_RESIDUE) && (handle_r == session_handle);
   assign epc_hit_c  = (state_r == ST_EXEC) && bank_ok_c &&
                       (word_pointer_r + 16'(exec_idx_r) >= EPC_PC_ADDR) &&
                       (word_pointer_r + 16'(exec_idx_r) <= EPC_LAST_ADR);
   assign code_c     = {opc_r[6:0], rx_bit};
   assign dec_c      = utd_decode(code_c, n_c);
   assign decide_c   = (n_c == LEN_OPC_S && !code_c[1]) || (n_c == LEN_OPC_L) ||
                       (n_c == LEN_OPC_M && code_c[3:2] == 2'h2);
   assign take_c     = (state_r == ST_OPC) && (cmd_r == CMD_NONE) && rx_bit_valid && decide_c &&
                       !rx_frame_start && !rx_frame_end;

   // Frame parser
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         state_r        <= ST_IDLE;
         cmd_r          <= CMD_NONE;
         bcnt_r         <= '0;
         opc_r          <= '0;
         bank_r         <= BANK_RSVD;
         ebv_blk_r      <= '0;
         word_pointer_r <= '0;
         word_count_a_r <= '0;
         data_r[0]      <= '0;
         data_r[1]      <= '0;
         handle_r       <= '0;
         overlong_r     <= 1'b0;
         exec_idx_r     <= '0;
      end else if (rx_frame_start && state_r != ST_EXEC) begin
         state_r        <= ST_OPC;
         cmd_r          <= CMD_NONE;
         bcnt_r         <= '0;
         opc_r          <= '0;
         word_pointer_r <= '0;
         overlong_r     <= 1'b0;
      end else if (state_r == ST_EXEC) begin
         exec_idx_r <= exec_idx_r + 8'h01;
         if (exec_idx_r + 8'h01 == word_count_a_r) begin
            state_r <= ST_IDLE;
         end
      end else if (rx_frame_end) begin
         exec_idx_r <= '0;
         state_r    <= (accept_c && bank_ok_c && count_ok_c) ? ST_EXEC : ST_IDLE;
      end else if (rx_bit_valid) begin
         bcnt_r <= n_c;
         case (state_r)
            ST_OPC: begin
               opc_r <= {opc_r[14:0], rx_bit};
               // decode at bit 2, 4 or 8
               if (decide_c) begin
                  cmd_r <= dec_c;
                  // Only the multi-word commands read on past the opcode
                  if (dec_c != CMD_MWRITE && dec_c != CMD_MERASE) begin
                     state_r <= ST_SKIP;
                  end
               end else if (n_c == LEN_OPC_FLD) begin
                  state_r <= ST_BANK;
                  bcnt_r  <= '0;
               end
            end
            ST_BANK: begin
               bank_r <= {bank_r[0], rx_bit};
               if (n_c == LEN_BANK) begin
                  state_r <= ST_PTR;
                  bcnt_r  <= '0;
               end
            end
            ST_PTR: begin
               ebv_blk_r <= {ebv_blk_r[6:0], rx_bit};
               // 7 payload bits per block, top bit continues
               if (n_c == LEN_EBV_BLK) begin
                  word_pointer_r <= {word_pointer_r[8:0], ebv_blk_r[5:0], rx_bit};
                  bcnt_r         <= '0;
                  if (!ebv_blk_r[EBV_CONT_BIT - 1]) begin
                     state_r <= ST_CNT;
                  end
               end
            end
            ST_CNT: begin
               word_count_a_r <= {word_count_a_r[6:0], rx_bit};
               if (n_c == LEN_CNT) begin
                  bcnt_r  <= '0;
                  state_r <= (is_write_c && {word_count_a_r[6:0], rx_bit} != 8'h00)
                             ? ST_DATA : ST_HANDLE;
               end
            end
            ST_DATA: begin
               // Words past the second are counted but not kept
               if (bcnt_r[11:4] < 8'h02) begin
                  data_r[bcnt_r[4]] <= {data_r[bcnt_r[4]][14:0], rx_bit};
               end
               if (n_c == {word_count_a_r, 4'h0}) begin
                  state_r <= ST_HANDLE;
                  bcnt_r  <= '0;
               end
            end
            ST_HANDLE: begin
               handle_r <= {handle_r[14:0], rx_bit};
               if (n_c == LEN_HANDLE) begin
                  state_r <= ST_CRC;
                  bcnt_r  <= '0;
               end
            end
            ST_CRC: begin
               if (n_c == LEN_CRC) begin
                  state_r <= ST_END;
               end
            end
            ST_END: begin
               overlong_r <= 1'b1;
            end
            default: begin
            end
         endcase
      end
   end

   // Running CRC over the whole frame
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         crc_r <= CRC_PRESET;
      end else if (rx_frame_start) begin
         crc_r <= CRC_PRESET;
      end else if (rx_bit_valid) begin
         crc_r <= utd_crc_step(crc_r, rx_bit);
      end
   end

   // Command strobe, memory port and replies
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         cmd_pulse      <= 1'b0;
         cmd_id         <= CMD_NONE;
         mem_wr         <= 1'b0;
         mem_wr_addr    <= '0;
         mem_wr_data    <= '0;
         reply_ok       <= 1'b0;
         reply_err      <= 1'b0;
         reply_err_code <= ERR_OTHER;
      end else begin
         cmd_pulse <= take_c;
         // Held until the next decoded opcode, so status shows the last command
         if (take_c) begin
            cmd_id <= dec_c;
         end
         mem_wr      <= (state_r == ST_EXEC);
         mem_wr_addr <= word_pointer_r + 16'(exec_idx_r);
         mem_wr_data <= is_write_c ? data_r[exec_idx_r[0]] : ERASE_VALUE;
         reply_ok    <= (state_r == ST_EXEC) && (exec_idx_r + 8'h01 == word_count_a_r);
         // bank fault is other error, count fault is overrun
         reply_err   <= accept_c && !(bank_ok_c && count_ok_c);
         if (accept_c) begin
            reply_err_code <= bank_ok_c ? ERR_OVERRUN : ERR_OTHER;
         end
      end
   end

   // Stored CRC word; invalidation wins over a same-cycle store
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         stored_crc_word  <= CRC_RST_VAL;
         stored_crc_valid <= 1'b0;
      end else if (epc_hit_c || epc_write_evt) begin
         stored_crc_valid <= 1'b0;
      end else if (ack_reply_end && ack_reply_full) begin
         stored_crc_word  <= ack_reply_crc;
         stored_crc_valid <= 1'b1;
      end
      // truncated reply leaves the word untouched
   end

   // Avalon-MM slave: one wait state on every access
   always_ff @(posedge clk_sys or negedge arst_n) begin
      if (!arst_n) begin
         wait_r  <= 1'b1;
         rdata_r <= '0;
         en_r    <= CTRL_EN_RST;
      end else begin
         wait_r <= !((avs_read || avs_write) && wait_r);
         if (avs_read && wait_r) begin
            case (avs_address)
               REG_CTRL:   rdata_r <= 32'(en_r) << CTRL_EN_BIT;
               REG_STATUS: rdata_r <= (32'(stored_crc_valid) << ST_VALID_BIT) |
                                      (32'(state_r == ST_EXEC) << ST_BUSY_BIT) |
                                      (32'(reply_err_code) << ST_ERR_LSB) |
                                      (32'(cmd_id) << ST_CMD_LSB);
               REG_CRC:    rdata_r <= 32'(stored_crc_word);
               REG_LAST:   rdata_r <= 32'(word_pointer_r) |
                                      (32'(word_count_a_r) << LAST_CNT_LSB);
               default:    rdata_r <= 32'h0000_0000;
            endcase
         end
         if (avs_write && !wait_r && avs_address == REG_CTRL && avs_byteenable[0]) begin
            en_r <= avs_writedata[CTRL_EN_BIT];
         end
      end
   end

   assign avs_waitrequest = wait_r;
   assign avs_readdata    = rdata_r;

   property p_ack_code;
      @(posedge clk_sys) disable iff (!arst_n)
      (state_r == ST_OPC && rx_bit_valid && !rx_frame_start && !rx_frame_end &&
       bcnt_r == 12'h001 && {opc_r[0], rx_bit} == 2'b01)
      |=> cmd_pulse && cmd_id == CMD_ACK;
   endproperty
   a_ack_code: assert property (p_ack_code) else $error("ACK code not decoded");

   property p_mand_code;
      @(posedge clk_sys) disable iff (!arst_n)
      (state_r == ST_OPC && rx_bit_valid && !rx_frame_start && !rx_frame_end &&
       cmd_r == CMD_NONE && bcnt_r == 12'h007 && {opc_r[6:0], rx_bit} == OPC_ACCESS)
      |=> cmd_pulse && cmd_id == CMD_MANDATORY ##1 state_r == ST_SKIP || state_r == ST_IDLE;
   endproperty
   a_mand_code: assert property (p_mand_code) else $error("Mandatory code missed");

   property p_bank;
      @(posedge clk_sys) disable iff (!arst_n)
      accept_c && !bank_ok_c |=> reply_err && reply_err_code == ERR_OTHER && !mem_wr;
   endproperty
   a_bank: assert property (p_bank) else $error("Bad bank not refused");

   property p_wcount;
      @(posedge clk_sys) disable iff (!arst_n)
      accept_c && bank_ok_c && is_write_c && word_count_a_r > MW_CNT_MAX
      |=> reply_err && reply_err_code == ERR_OVERRUN ##1 !mem_wr;
   endproperty
   a_wcount: assert property (p_wcount) else $error("Write count not refused");

   property p_ecount;
      @(posedge clk_sys) disable iff (!arst_n)
      accept_c && bank_ok_c && !is_write_c &&
      (word_count_a_r == 8'h00 || word_count_a_r > ME_CNT_MAX)
      |=> reply_err ##1 !mem_wr && state_r == ST_IDLE;
   endproperty
   a_ecount: assert property (p_ecount) else $error("Erase count not refused");

   property p_invalid;
      @(posedge clk_sys) disable iff (!arst_n)
      mem_wr && mem_wr_addr >= EPC_PC_ADDR && mem_wr_addr <= EPC_LAST_ADR
      |-> !stored_crc_valid;
   endproperty
   a_invalid: assert property (p_invalid) else $error("CRC still valid");

   property p_store;
      @(posedge clk_sys) disable iff (!arst_n)
      ack_reply_end && ack_reply_full && !epc_hit_c && !epc_write_evt
      |=> stored_crc_valid && stored_crc_word == $past(ack_reply_crc);
   endproperty
   a_store: assert property (p_store) else $error("Reply CRC not stored");

   property p_trunc;
      @(posedge clk_sys) disable iff (!arst_n)
      ack_reply_end && !ack_reply_full |=> $stable(stored_crc_word);
   endproperty
   a_trunc: assert property (p_trunc) else $error("Stored CRC changed");

   property p_crc_drop;
      @(posedge clk_sys) disable iff (!arst_n)
      state_r == ST_END && rx_frame_end && crc_r != CRC_RESIDUE
      |=> (!reply_err && !mem_wr && !reply_ok) [*3];
   endproperty
   a_crc_drop: assert property (p_crc_drop) else $error("Bad CRC acted on");

   property p_handle;
      @(posedge clk_sys) disable iff (!arst_n)
      state_r == ST_END && rx_frame_end && handle_r != session_handle
      |=> (!reply_err && !mem_wr) [*3];
   endproperty
   a_handle: assert property (p_handle) else $error("Foreign handle acted on");

   c_write_done: cover property (@(posedge clk_sys) disable iff (!arst_n) reply_ok && is_write_c);
   c_erase_done: cover property (@(posedge clk_sys) disable iff (!arst_n) reply_ok && !is_write_c);
   c_err_reply:  cover property (@(posedge clk_sys) disable iff (!arst_n) reply_err);
   c_crc_store:  cover property (@(posedge clk_sys) disable iff (!arst_n)
                                 !stored_crc_valid ##1 stored_crc_valid);

endmodule // utd_cmd_decoder

// file: utd_reader_model.sv
// Reader-side model that serialises command frames onto the bit link
`timescale 1ns/1ps
module utd_reader_model (
   input  wire logic clk_sys,
   output logic      rx_frame_start,
   output logic      rx_frame_end,
   output logic      rx_bit_valid,
   output logic      rx_bit
);
   initial begin
      rx_frame_start = 1'b0;
      rx_frame_end   = 1'b0;
      rx_bit_valid   = 1'b0;
      rx_bit         = 1'b0;
   end
   task automatic send(input logic q[$], input logic bad);
      logic [15:0] c;
      c = 16'hFFFF;
      foreach (q[i]) c = {c[14:0], 1'b0} ^ ((c[15] ^ q[i]) ? 16'h1021 : 16'h0000);
      c = ~c ^ {15'h0000, bad};
      for (int i = 15; i >= 0; i--) q.push_back(c[i]);
      @(posedge clk_sys);
      rx_frame_start <= 1'b1;
      foreach (q[i]) begin
         @(posedge clk_sys);
         rx_frame_start <= 1'b0;
         rx_bit_valid   <= 1'b1;
         rx_bit         <= q[i];
      end
      // Idle line must not keep the last bit
      @(posedge clk_sys);
      rx_bit_valid <= 1'b0;
      rx_bit       <= ~q[$];
      rx_frame_end <= 1'b1;
      @(posedge clk_sys);
      rx_frame_end <= 1'b0;
   endtask
endmodule // utd_reader_model

// file: utd_cmd_decoder_test.sv
// Self-checking bench for the tag command decoder
`timescale 1ns/1ps
module utd_cmd_decoder_test;
   import utd_pkg::*;
   logic        clk_sys, arst_n, avs_read, avs_write, avs_waitrequest, epc_write_evt;
   logic        ack_reply_end, ack_reply_full, rx_frame_start, rx_frame_end, rx_bit_valid;
   logic        rx_bit, cmd_pulse, mem_wr, reply_ok, reply_err, stored_crc_valid;
   logic [4:0]  avs_address;
   logic [3:0]  avs_byteenable, cmd_id, last_cmd;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [15:0] session_handle, ack_reply_crc, mem_wr_addr, mem_wr_data, stored_crc_word;
   logic [7:0]  reply_err_code, last_code;
   logic [15:0] wa[$], wd[$];
   logic        q[$];
   int          num_errors, num_checks, n_ok, n_err;
   utd_cmd_decoder i_utd_cmd_decoder (.clk_sys, .arst_n, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_byteenable, .avs_readdata, .avs_waitrequest, .rx_frame_start,
      .rx_frame_end, .rx_bit_valid, .rx_bit, .session_handle, .epc_write_evt, .ack_reply_end,
      .ack_reply_full, .ack_reply_crc, .cmd_pulse, .cmd_id, .mem_wr, .mem_wr_addr,
      .mem_wr_data, .reply_ok, .reply_err, .reply_err_code, .stored_crc_word, .stored_crc_valid);
   utd_reader_model i_utd_reader_model (.clk_sys, .rx_frame_start, .rx_frame_end,
      .rx_bit_valid, .rx_bit);
   always #25 clk_sys = ~clk_sys;
   always @(posedge clk_sys) begin
      if (cmd_pulse === 1'b1) last_cmd <= cmd_id;
      if (mem_wr === 1'b1) begin
         wa.push_back(mem_wr_addr);
         wd.push_back(mem_wr_data);
      end
      if (reply_ok === 1'b1) n_ok++;
      if (reply_err === 1'b1) begin
         n_err++;
         last_code <= reply_err_code;
      end
   end
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         num_errors++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic final_report();
      $display("Checks %0d, errors %0d", num_checks, num_errors);
      if (num_errors == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // Bus access held until waitrequest is seen low
   task automatic avs(input logic wr, input logic [4:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_sys);
      avs_read      <= ~wr;
      avs_write     <= wr;
      avs_address   <= a;
      avs_writedata <= d;
      do begin
         @(posedge clk_sys);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      rd = avs_readdata;
      avs_read  <= 1'b0;
      avs_write <= 1'b0;
      if (n >= 50) begin
         num_errors++;
         final_report();
      end
   endtask
   task automatic put(input logic [15:0] v, input int n);
      for (int i = n - 1; i >= 0; i--) q.push_back(v[i]);
   endtask
   // field order; fault 1 breaks the trailer, 2 the handle
   task automatic mw(input logic [7:0] opc, input logic [1:0] bank, input logic [15:0] ptr,
                     input int pn, input logic [7:0] cnt, input logic [1:0] fault,
                     input int en, input logic [15:0] ea, input int ee, input logic [7:0] ec);
      q.delete();
      wa.delete();
      wd.delete();
      n_ok = 0;
      n_err = 0;
      put({opc, 8'h00}, 16);
      put({14'h0000, bank}, 2);
      put(ptr, pn);
      put({8'h00, cnt}, 8);
      if (opc == OPC_MWRITE) for (int i = 0; i < cnt; i++) put(16'hA000 + 16'(i), 16);
      put(fault == 2'h2 ? ~session_handle : session_handle, 16);
      i_utd_reader_model.send(q, fault == 2'h1);
      repeat (14) @(posedge clk_sys);
      chk(wa.size(), en);
      foreach (wa[i]) begin
         chk(wa[i], ea + 16'(i));
         chk(wd[i], opc == OPC_MWRITE ? 16'hA000 + 16'(i) : ERASE_VALUE);
      end
      chk(n_ok, en > 0);
      chk(n_err, ee);
      if (ee > 0) chk(last_code, ec);
   endtask
   task automatic ack(input logic full, input logic [15:0] c);
      @(posedge clk_sys);
      ack_reply_end  <= 1'b1;
      ack_reply_full <= full;
      ack_reply_crc  <= c;
      @(posedge clk_sys);
      ack_reply_end <= 1'b0;
      ack_reply_crc <= ~c;
      repeat (2) @(posedge clk_sys);
   endtask
   initial begin
      {clk_sys, arst_n, avs_read, avs_write, epc_write_evt, ack_reply_end} = 6'h00;
      {ack_reply_full, avs_address, avs_writedata, ack_reply_crc} = '0;
      {last_cmd, last_code, num_errors, num_checks} = '0;
      avs_byteenable = 4'hF;
      session_handle = 16'h5A5A;
      repeat (16) @(posedge clk_sys);
      arst_n <= 1'b1;
      @(posedge clk_sys);
      chk({stored_crc_valid, stored_crc_word, cmd_id}, 0);
      avs(1'b0, REG_CTRL, 0);
      chk(rd, 32'h1);
      avs(1'b0, 5'h10, 0);
      chk(rd, 0);
      ack(1'b0, 16'h1234);
      chk({stored_crc_valid, stored_crc_word}, 17'h00000);
      ack(1'b1, 16'hBEEF);
      chk({stored_crc_valid, stored_crc_word}, 17'h1BEEF);
      avs(1'b0, REG_CRC, 0);
      chk(rd, 32'hBEEF);
      @(posedge clk_sys);
      epc_write_evt <= 1'b1;
      @(posedge clk_sys);
      epc_write_evt <= 1'b0;
      ack(1'b0, 16'h1234);
      chk({stored_crc_valid, stored_crc_word}, 17'h0BEEF);
      ack(1'b1, 16'hC0DE);
      for (int i = 0; i < 15; i++) begin
         q.delete();
         last_cmd = 4'h0;
         if (i < 2) put(16'(i), 2);
         else if (i < 5) put(16'(i + 6), 4);
         else put(16'(8'hC0 + i - 5), 8);
         i_utd_reader_model.send(q, 1'b0);
         repeat (4) @(posedge clk_sys);
         chk(last_cmd, i < 5 ? i + 1 : (i < 12 ? 6 : i - 5));
      end
      mw(OPC_MWRITE, BANK_EPC, 16'h0003, 8, 8'h01, 2'h0, 1, 16'h0003, 0, 0);
      chk(stored_crc_valid, 0);
      mw(OPC_MWRITE, BANK_EPC, 16'h8105, 16, 8'h02, 2'h0, 2, 16'h0085, 0, 0);
      avs(1'b0, REG_LAST, 0);
      chk(rd, {8'h00, 8'h02, 16'h0085});
      mw(OPC_MWRITE, BANK_EPC, 16'h0001, 8, 8'h03, 2'h0, 0, 0, 1, ERR_OVERRUN);
      avs(1'b0, REG_STATUS, 0);
      chk(rd, {12'h000, 4'(CMD_MWRITE), ERR_OVERRUN, 8'h00});
      mw(OPC_MWRITE, BANK_RSVD, 16'h0001, 8, 8'h01, 2'h0, 0, 0, 1, ERR_OTHER);
      mw(OPC_MERASE, BANK_EPC, 16'h0002, 8, 8'h08, 2'h0, 8, 16'h0002, 0, 0);
      mw(OPC_MERASE, BANK_EPC, 16'h0009, 8, 8'h01, 2'h0, 1, 16'h0009, 0, 0);
      mw(OPC_MERASE, BANK_EPC, 16'h0002, 8, 8'h00, 2'h0, 0, 0, 1, ERR_OVERRUN);
      mw(OPC_MERASE, BANK_EPC, 16'h0002, 8, 8'h09, 2'h0, 0, 0, 1, ERR_OVERRUN);
      mw(OPC_MERASE, BANK_RSVD, 16'h0002, 8, 8'h01, 2'h0, 0, 0, 1, ERR_OTHER);
      mw(OPC_MWRITE, BANK_EPC, 16'h0003, 8, 8'h01, 2'h1, 0, 0, 0, 0);
      mw(OPC_MERASE, BANK_EPC, 16'h0003, 8, 8'h01, 2'h2, 0, 0, 0, 0);
      avs(1'b1, REG_CTRL, 0);
      mw(OPC_MWRITE, BANK_EPC, 16'h0003, 8, 8'h01, 2'h0, 0, 0, 0, 0);
      avs(1'b1, REG_CTRL, 1);
      mw(OPC_MWRITE, BANK_EPC, 16'h0004, 8, 8'h01, 2'h0, 1, 16'h0004, 0, 0);
      final_report();
   end
endmodule // utd_cmd_decoder_test
